// [rtl/glpe_defines.vh]
`ifndef GLPE_DEFINES_VH
`define GLPE_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
// Register indices; each register is one aligned word, so its byte address is four times its index.
`define GLPE_IDX_LOW_CFG 8'h57
`define GLPE_IDX_HIGH_CFG 8'h58
`define GLPE_IDX_CTRL 8'h5A
`define GLPE_IDX_STATUS 8'h5B
`define GLPE_ADDR_LOW_CFG 12'h15C
`define GLPE_ADDR_HIGH_CFG 12'h160
`define GLPE_ADDR_CTRL 12'h168
`define GLPE_ADDR_STATUS 12'h16C
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define GLPE_TB_MSB 15
`define GLPE_TB_LSB 14
`define GLPE_HC_MSB 13
`define GLPE_HC_LSB 7
`define GLPE_LC_MSB 6
`define GLPE_LC_LSB 0
`define GLPE_LOW_CFG_RESET 16'h007F
`define GLPE_HIGH_CFG_RESET 16'h3F80
`define GLPE_HIGH_CFG_MASK 16'h3FFF
// ----------------------------------------
// Time base lengths in clock periods
// ----------------------------------------
`define GLPE_TB0_CYCLES 11'h010
`define GLPE_TB1_CYCLES 11'h040
`define GLPE_TB2_CYCLES 11'h100
`define GLPE_TB3_CYCLES 11'h400
`endif

// [rtl/glpe_tick_gen.v]
`include "glpe_defines.vh"

// ----------------------------------------
// Time base tick generator
// ----------------------------------------
module glpe_tick_gen
(
	input wire pclk, // Master clock.
	input wire presetn, // Asynchronous reset, active low.
	input wire [1:0] tb_sel, // Time base selector.
	input wire restart, // Restart the tick phase.
	output reg tick // One-cycle pulse per time base.
);

	reg [10:0] cnt_reg;
	reg [10:0] len;

	// Decode the selector into a tick length in clock periods.
	always @*
	begin
		case (tb_sel)
			2'b00: len = `GLPE_TB0_CYCLES;
			2'b01: len = `GLPE_TB1_CYCLES;
			2'b10: len = `GLPE_TB2_CYCLES;
			default: len = `GLPE_TB3_CYCLES;
		endcase
	end

	// Count up one time base; a restart realigns the phase.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 11'h000;
			tick <= 1'b0;
		end
		else if (restart || cnt_reg >= len - 11'h001)
		begin
			cnt_reg <= 11'h000;
			tick <= !restart;
		end
		else
		begin
			cnt_reg <= cnt_reg + 11'h001;
			tick <= 1'b0;
		end
	end

endmodule

// [rtl/glpe_top.v]
// Register access over APB was decided locally.
`include "glpe_defines.vh"

// ----------------------------------------
// PWM level encoder with APB registers
// ----------------------------------------
module glpe_top
(
	input wire pclk, // Master clock.
	input wire presetn, // Asynchronous reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB enable.
	input wire pwrite, // APB direction, high for write.
	input wire [11:0] paddr, // APB byte address.
	input wire [31:0] pwdata, // APB write data.
	output reg [31:0] prdata, // APB read data.
	output reg pready, // APB ready.
	output reg pslverr, // APB error on unmapped address.
	output reg pin_out, // Shared pin output level.
	output reg pin_oe, // Shared pin output enable.
	output reg [1:0] decoder_tb_sel, // Time base for the input decoder.
	output reg decoder_tick // Time base tick for the input decoder.
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [15:0] low_cfg_reg;
	reg [15:0] high_cfg_reg;
	reg [1:0] ctrl_reg; // Bit 0 output enable, bit 1 commanded level.
	reg level_q_reg;
	reg [6:0] phase_cnt_reg;
	reg phase_high_reg;
	reg [31:0] rdata_next;
	reg hit;
	wire tick;
	wire apb_access;
	wire apb_write;
	wire [1:0] tb_sel;
	wire level_change;
	wire [6:0] act_hc;
	wire [6:0] act_lc;

	// Hold the answer one cycle so every APB output comes from a flop.
	assign apb_access = psel && penable && !pready;
	assign apb_write = apb_access && pwrite && hit;

	// Address decode shared by reads and writes.
	always @*
	begin
		hit = 1'b1;
		rdata_next = 32'h00000000;
		case (paddr)
			`GLPE_ADDR_LOW_CFG: rdata_next = {16'h0000, low_cfg_reg};
			`GLPE_ADDR_HIGH_CFG: rdata_next = {16'h0000, high_cfg_reg & `GLPE_HIGH_CFG_MASK};
			`GLPE_ADDR_CTRL: rdata_next = {30'h00000000, ctrl_reg};
			`GLPE_ADDR_STATUS: rdata_next = {22'h000000, phase_cnt_reg, phase_high_reg, level_q_reg, pin_out};
			default: hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			low_cfg_reg <= `GLPE_LOW_CFG_RESET;
			high_cfg_reg <= `GLPE_HIGH_CFG_RESET;
			ctrl_reg <= 2'b00;
		end
		else
		begin
			pready <= apb_access;
			pslverr <= apb_access && !hit;
			prdata <= (apb_access && !pwrite) ? rdata_next : 32'h00000000;
			if (apb_write && paddr == `GLPE_ADDR_LOW_CFG)
				low_cfg_reg <= pwdata[15:0];
			if (apb_write && paddr == `GLPE_ADDR_HIGH_CFG)
				high_cfg_reg <= pwdata[15:0] & `GLPE_HIGH_CFG_MASK;
			if (apb_write && paddr == `GLPE_ADDR_CTRL)
				ctrl_reg <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Count pair selection
	// ----------------------------------------
	assign tb_sel = low_cfg_reg[`GLPE_TB_MSB:`GLPE_TB_LSB];
	assign level_change = ctrl_reg[1] != level_q_reg;
	// The commanded level picks its own pair of counts.
	assign act_hc = level_q_reg ? high_cfg_reg[`GLPE_HC_MSB:`GLPE_HC_LSB]
		: low_cfg_reg[`GLPE_HC_MSB:`GLPE_HC_LSB];
	assign act_lc = level_q_reg ? high_cfg_reg[`GLPE_LC_MSB:`GLPE_LC_LSB]
		: low_cfg_reg[`GLPE_LC_MSB:`GLPE_LC_LSB];

	glpe_tick_gen u_tick
	(
		.pclk(pclk),
		.presetn(presetn),
		.tb_sel(tb_sel),
		.restart(level_change),
		.tick(tick)
	);

	// ----------------------------------------
	// Waveform generator
	// ----------------------------------------
	// A period is high for act_hc ticks then low for act_lc ticks, so its
	// length is their sum. A config write takes effect on the next clock, even mid-phase.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			level_q_reg <= 1'b0;
			phase_cnt_reg <= 7'h00;
			phase_high_reg <= 1'b1;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			decoder_tb_sel <= 2'b00;
			decoder_tick <= 1'b0;
		end
		else
		begin
			pin_oe <= ctrl_reg[0];
			decoder_tb_sel <= tb_sel;
			decoder_tick <= tick;
			if (level_change)
			begin
				// Fresh period on a level change.
				level_q_reg <= ctrl_reg[1];
				phase_cnt_reg <= 7'h00;
				phase_high_reg <= 1'b1;
			end
			else if (act_hc == 7'h00)
			begin
				pin_out <= 1'b0;
				phase_cnt_reg <= 7'h00;
				phase_high_reg <= 1'b1;
			end
			else if (act_lc == 7'h00)
			begin
				pin_out <= 1'b1;
				phase_cnt_reg <= 7'h00;
				phase_high_reg <= 1'b1;
			end
			else
			begin
				pin_out <= phase_high_reg;
				if (tick)
				begin
					if (phase_high_reg && phase_cnt_reg >= act_hc - 7'h01)
					begin
						phase_high_reg <= 1'b0;
						phase_cnt_reg <= 7'h00;
					end
					else if (!phase_high_reg && phase_cnt_reg >= act_lc - 7'h01)
					begin
						phase_high_reg <= 1'b1;
						phase_cnt_reg <= 7'h00;
					end
					else
						phase_cnt_reg <= phase_cnt_reg + 7'h01;
				end
			end
		end
	end

endmodule

// [testbench/glpe_asserts.sv]
// ----------------------------------------
// Port checks
// ----------------------------------------
module glpe_asserts
(
	input wire pclk, // Clock.
	input wire presetn, // Reset.
	input wire psel, // Select.
	input wire penable, // Enable.
	input wire pwrite, // Write.
	input wire [11:0] paddr, // Address.
	input wire [31:0] pwdata, // Data in.
	input wire [31:0] prdata, // Data out.
	input wire pready, // Ready.
	input wire pslverr, // Error.
	input wire pin_oe, // Enable.
	input wire [1:0] decoder_tb_sel, // Select.
	input wire decoder_tick // Tick.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers come one cycle after the access phase starts and last one cycle.
	access_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("late ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("long ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("stray read data");
	unmapped_err_a: assert property (pready && paddr > 12'h16C |-> pslverr)
		else $error("no error");
	reserved_zero_a: assert property (pready && !pwrite && paddr == 12'h160 |-> prdata[31:14] == 18'h0)
		else $error("reserved bits set");
	// Checked two cycles on, so a slow register copy still has time to land.
	tb_copy_a: assert property (pready && pwrite && paddr == 12'h15C |-> ##2 decoder_tb_sel == $past(pwdata[15:14], 2))
		else $error("time base copy");
	tick_space_a: assert property (decoder_tick && decoder_tb_sel == 2'h0 |=> !decoder_tick [*8])
		else $error("tick too soon");
	oe_follow_a: assert property (pready && pwrite && paddr == 12'h168 |-> ##2 pin_oe == $past(pwdata[0], 2))
		else $error("enable lost");
endmodule

// [testbench/glpe_rx_model.sv]
// ----------------------------------------
// Receiver timing the pin levels
// ----------------------------------------
module glpe_rx_model
(
	input wire pclk, // Clock.
	input wire presetn, // Reset.
	input wire pin, // Pin level.
	output int hi_len, // Last high run.
	output int lo_len // Last low run.
);
	timeunit 1ns;
	timeprecision 1ns;
	int run;
	logic last;
	// Edge-to-edge timing, so a static level leaves the last runs untouched.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run <= 0;
			last <= 1'b0;
			hi_len <= 0;
			lo_len <= 0;
		end
		else if (pin !== last)
		begin
			if (last)
				hi_len <= run;
			else
				lo_len <= run;
			run <= 1;
			last <= pin;
		end
		else
			run <= run + 1;
	end
endmodule

// [testbench/test_gpio_pwm_level_encoder.sv]
// ----------------------------------------
// Bench
// ----------------------------------------
module test_gpio_pwm_level_encoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] r;
	logic e;
	wire [31:0] prdata;
	wire pready, pslverr, pin_out, pin_oe, decoder_tick;
	wire [1:0] decoder_tb_sel;
	int hi_len, lo_len, n;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #10 pclk = ~pclk;
	glpe_top glpe_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
		.decoder_tb_sel(decoder_tb_sel), .decoder_tick(decoder_tick));
	// A released pin is taken as pulled low.
	glpe_rx_model glpe_rx_model_inst (.pclk(pclk), .presetn(presetn),
		.pin(pin_oe ? pin_out : 1'b0), .hi_len(hi_len), .lo_len(lo_len));
	// Pin edges may land one cycle either way, hence the tolerance.
	task chk(input logic [31:0] g, input logic [31:0] x, input int tol);
		cmp_count++;
		if (g === x || (tol > 0 && (g + tol >= x) === 1'b1 && (g <= x + tol) === 1'b1))
			return;
		n_mismatch++;
		$display("BAD %0t got %h exp %h", $time, g, x);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		if (k >= 50)
			n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk(r, x, 0);
		chk({31'h0, e}, {31'h0, xe}, 0);
	endtask
	// The level is toggled first so every setting starts a fresh period.
	task pwm(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] ctl);
		apb(1'b1, 12'h15C, lo);
		apb(1'b1, 12'h160, hi);
		apb(1'b1, 12'h168, ctl ^ 32'h2);
		apb(1'b1, 12'h168, ctl);
		repeat (800) @(posedge pclk);
	endtask
	task stat(input logic x);
		repeat (4)
		begin
			repeat (50) @(posedge pclk);
			chk({31'h0, pin_out}, {31'h0, x}, 0);
		end
	endtask
	task tk;
		n = 0;
		do begin @(posedge pclk); n++; end while (decoder_tick !== 1'b1 && n < 3000);
	endtask
	task wrap_up;
		$display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		wrap_up;
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h15C, 32'h007F, 1'b0);
		rd(12'h160, 32'h3F80, 1'b0);
		rd(12'h168, 32'h0, 1'b0);
		apb(1'b1, 12'h160, 32'hFFFF);
		rd(12'h160, 32'h3FFF, 1'b0);
		rd(12'h100, 32'h0, 1'b1);
		pwm(32'h0185, 32'h0101, 32'h1);
		chk(hi_len, 48, 1);
		chk(lo_len, 80, 1);
		pwm(32'h4185, 32'h0101, 32'h3);
		chk(hi_len, 128, 1);
		chk(lo_len, 64, 1);
		pwm(32'h4185, 32'h3F80, 32'h3);
		stat(1'b1);
		pwm(32'h4185, 32'h0005, 32'h3);
		stat(1'b0);
		pwm(32'h4185, 32'h0000, 32'h3);
		stat(1'b0);
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, 12'h15C, {16'h0, s[1:0], 14'h0185});
			tk;
			tk;
			chk(n, 16 << (2 * s), 0);
			chk({30'h0, decoder_tb_sel}, s, 0);
		end
		// Static low on the high level: count 0, high phase armed, level high, pin low.
		rd(12'h16C, 32'h6, 1'b0);
		wrap_up;
	end
endmodule
bind glpe_top glpe_asserts glpe_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin_oe(pin_oe), .decoder_tb_sel(decoder_tb_sel),
	.decoder_tick(decoder_tick));
